// File: tb/burst_wait_gen_sva.sv
`timescale 1ns/10ps

module burst_wait_gen_sva (
    input wire logic mclk, // clock
    input wire logic rstn, // reset, active low
    input wire logic chip_select_n, // select
    input wire logic code_read_strobe_n, // code read
    input wire logic data_read_strobe_n, // data read
    input wire logic write_low_byte_strobe_n, // low write
    input wire logic write_high_byte_strobe_n, // high write
    input wire logic [3:0] addr, // address
    input wire logic [3:0] wait_clock_count, // length
    input wire logic [1:0] wait_mode, // mode
    input wire logic stage_tap_en, // tap length
    input wire logic wait_out, // wait
    input wire logic addr_latch_open, // latch open
    input wire logic retrigger, // burst pulse
    input wire logic first_count_stage, // first stage
    input wire logic busy, // sequence running
    input wire logic [7:0] stage_view, // stage picture
    input wire logic [3:0] count_value // count
);
    logic idle;
    logic act;
    assign idle = code_read_strobe_n & data_read_strobe_n & write_low_byte_strobe_n
        & write_high_byte_strobe_n;
    assign act = !idle && !chip_select_n;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    no_select_a: assert property (chip_select_n |-> !wait_out)
        else $error("wait without select");
    no_strobe_a: assert property (idle |-> !wait_out)
        else $error("wait without strobe");
    latch_zero_a: assert property (addr_latch_open == (count_value == 4'h0))
        else $error("latch open mismatch");
    idle_clear_a: assert property (idle |=> count_value == 4'h0)
        else $error("count not cleared");
    first_stage_a: assert property (wait_mode < 2'h2 && act && count_value == 4'h0
        && (stage_tap_en || wait_clock_count != 4'h0) |=> count_value == 4'h1)
        else $error("first stage late");
    reg_len_a: assert property (wait_mode == 2'h0 && !stage_tap_en && act
        && count_value != 4'h0 |-> wait_out == (count_value < wait_clock_count))
        else $error("registered wait length wrong");
    comb_wait_a: assert property (wait_mode == 2'h1 && act && count_value == 4'h0
        |-> wait_out == (stage_tap_en || wait_clock_count != 4'h0))
        else $error("combinational wait late");
    burst_restart_a: assert property (!code_read_strobe_n && !chip_select_n
        && count_value != 4'h0 && $past(count_value) != 4'h0
        && addr[3:1] != $past(addr[3:1]) |=> count_value == 4'h0 && retrigger)
        else $error("burst not restarted");
    first_view_a: assert property (first_count_stage == (count_value != 4'h0)
        && stage_view[0] == (count_value != 4'h0) && stage_view[7] == (count_value > 4'h7))
        else $error("stage view wrong");
    busy_clear_a: assert property (idle |=> !busy)
        else $error("busy without strobe");
endmodule

bind burst_wait_gen burst_wait_gen_sva sva_u (.*);

// File: tb/burst_wait_gen_tb.sv
`timescale 1ns/10ps

module burst_wait_gen_tb;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic cs_n;
    logic [3:0] stb_n;
    logic [3:0] addr;
    logic bm = 1'b0;
    logic [3:0] tgt = 4'h6;
    logic [1:0] mode = 2'h0;
    logic tap_en = 1'b0;
    logic [2:0] tap = 3'h0;
    logic wait_out;
    logic done_p;
    logic retr_p;
    logic abn_p;
    logic [3:0] seq_len;
    logic [7:0] rnd = 8'h45;
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    int done_n;
    int retr_n;
    int abn_n;
    int wait_n;

    burst_wait_gen dut_u (.mclk(mclk), .rstn(rstn), .chip_select_n(cs_n),
        .code_read_strobe_n(stb_n[3]), .data_read_strobe_n(stb_n[2]),
        .write_low_byte_strobe_n(stb_n[1]), .write_high_byte_strobe_n(stb_n[0]),
        .addr(addr), .byte_bus_mode(bm), .wait_clock_count(tgt), .wait_mode(mode),
        .stage_tap_en(tap_en), .stage_tap(tap), .wait_out(wait_out),
        .first_count_stage(), .addr_latch_open(), .count_value(), .stage_view(),
        .busy(), .retrigger(retr_p), .sequence_done(done_p), .abandoned(abn_p),
        .last_seq_len(seq_len));
    cpu_bus_model bus_u (.mclk(mclk), .wait_out(wait_out), .chip_select_n(cs_n),
        .strobe_n(stb_n), .addr(addr));

    always #20 mclk = ~mclk;

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic complete_run();
        if (error_cnt == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    always @(posedge mclk) begin
        cyc++;
        if (done_p === 1'b1) done_n++;
        if (retr_p === 1'b1) retr_n++;
        if (abn_p === 1'b1) abn_n++;
        if (wait_out === 1'b1) wait_n++;
        if (cyc == 20000) begin
            error_cnt++;
            complete_run();
        end
    end

    task automatic cfg(input logic [1:0] m, input logic [3:0] t, input logic e,
            input logic [2:0] p);
        @(posedge mclk);
        mode <= m;
        tgt <= t;
        tap_en <= e;
        tap <= p;
    endtask

    // the reference counts one completion per sequence and one restart per burst address change
    task automatic run(input logic c, input logic [3:0] s, input logic [3:0] a,
            input logic [3:0] a2, input int b, input logic byte_mode);
        logic [3:0] m;
        int rexp;
        int dexp;
        m = byte_mode ? 4'hf : 4'he;
        @(posedge mclk);
        bm <= byte_mode;
        #1;
        done_n = 0;
        retr_n = 0;
        abn_n = 0;
        wait_n = 0;
        bus_u.cycle(c, s, a, a2, b);
        repeat (4) @(posedge mclk);
        rexp = (!c && s[3:2] != 2'h3 && ((a ^ a2) & m) != 4'h0 && b > 0) ? b : 0;
        dexp = (c || b < 0) ? 0 : 1 + rexp;
        check(8'(retr_n), 8'(rexp));
        check(8'(done_n), 8'(dexp));
        check(8'(abn_n), {7'h0, !c && b < 0});
        if (dexp > 0) check({4'h0, seq_len}, {4'h0, tap_en ? {1'b0, tap} + 4'h1 : tgt});
    endtask

    initial begin
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            cfg(k[1:0], 4'h2 + {1'b0, rnd[2:0]}, 1'b0, 3'h0);
            run(1'b0, 4'h7, rnd[3:0], rnd[3:0] ^ 4'h2, 2, 1'b0);
        end
        cfg(2'h0, 4'h6, 1'b0, 3'h0);
        run(1'b0, 4'hb, 4'h4, 4'h5, 1, 1'b1);
        run(1'b0, 4'hb, 4'h4, 4'h5, 1, 1'b0);
        run(1'b0, 4'hc, 4'h2, 4'h6, 1, 1'b0);
        run(1'b1, 4'h7, 4'h2, 4'h6, 1, 1'b0);
        check(8'(wait_n), 8'h0);
        run(1'b0, 4'hd, 4'h0, 4'h0, -1, 1'b0);
        cfg(2'h0, 4'h0, 1'b1, 3'h2);
        run(1'b0, 4'h7, 4'h8, 4'ha, 1, 1'b0);
        complete_run();
    end
endmodule

// File: tb/cpu_bus_model.sv
`timescale 1ns/10ps

module cpu_bus_model (
    input wire logic mclk, // clock
    input wire logic wait_out, // wait input
    output logic chip_select_n, // select
    output logic [3:0] strobe_n, // code, data, low, high
    output logic [3:0] addr // low address
);
    initial begin
        chip_select_n = 1'b1;
        strobe_n = 4'hf;
        addr = 4'h0;
    end

    // wait is read at the falling edge so the rising edge acts on a settled value
    task automatic cycle(input logic c, input logic [3:0] s, input logic [3:0] a,
            input logic [3:0] a2, input int b);
        int n;
        int i;
        n = 0;
        @(posedge mclk);
        chip_select_n <= c;
        strobe_n <= s;
        addr <= a;
        repeat (2) @(posedge mclk);
        while (n <= b) begin
            i = 0;
            @(negedge mclk);
            while (wait_out === 1'b1 && i < 40) begin
                @(negedge mclk);
                i++;
            end
            @(posedge mclk);
            repeat (n) @(posedge mclk);
            if (n < b) begin
                addr <= (n % 2 == 0) ? a2 : a;
                repeat (2) @(posedge mclk);
            end
            n++;
        end
        strobe_n <= 4'hf;
        chip_select_n <= 1'b1;
        addr <= ~addr;
    endtask
endmodule

// File: verilog/addr_watch.sv
`timescale 1ns/10ps
`include "wait_gen_map.svh"

module addr_watch (
    input wire logic mclk, // processor oscillator clock
    input wire logic rstn, // synchronous reset, active low
    input wire logic [`ADDR_W-1:0] addr, // non-multiplexed low address lines
    input wire logic byte_bus_mode, // 1: byte-wide data bus, watch a0 too
    input wire logic addr_latch_open, // latch transparent while high
    output logic [`ADDR_W-1:0] latched_addr, // address seen through the latch
    output logic addr_equal // watched bits match the latched value
);
    wait_gen_pkg::watch_s s_q;
    wait_gen_pkg::watch_s s_d;
    logic [`ADDR_W-1:0] watch_mask;
    logic [`ADDR_W-1:0] bit_diff;

    // transparent latch modelled as a bypass mux plus a holding register
    assign latched_addr = addr_latch_open ? addr : s_q.held;
    assign watch_mask = byte_bus_mode ? `ADDR_BYTE_MASK : `ADDR_WORD_MASK;

    genvar i;
    generate
        for (i = 0; i < `ADDR_W; i = i + 1) begin : g_cmp
            assign bit_diff[i] = watch_mask[i] & (addr[i] ^ latched_addr[i]);
        end
    endgenerate

    assign addr_equal = ~|bit_diff;

    always_comb begin
        s_d = s_q;
        if (addr_latch_open) begin
            s_d.held = addr;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule

// File: verilog/burst_wait_gen.sv
`timescale 1ns/10ps
`include "wait_gen_map.svh"

// Function
// - watch a1-a3, plus a0 in byte mode
// - address change after wait restarts sequence
// - wait from select and strobe until count
// - no strobe holds counter cleared
// - latch open at zero count, else holds
// - first stage sets one clock after strobe
// - retrigger on reads only, writes single sequence
// - four-bit up counter times the wait
// - wait length configurable, default six
// - no chip select, no wait
// - never wait without a strobe
// - one-shot fires on address-equal rising edge
// - wait taken from a register, glitch free
// - short strobes need wait 34ns early
// - earlier wait option for short strobes
// - raise wait only after strobe falls
// - combinational wait option

module burst_wait_gen (
    input wire logic mclk, // processor oscillator clock
    input wire logic rstn, // synchronous reset, active low
    input wire logic chip_select_n, // device select, active low
    input wire logic code_read_strobe_n, // code read strobe, active low
    input wire logic data_read_strobe_n, // data read strobe, active low
    input wire logic write_low_byte_strobe_n, // low byte write strobe, active low
    input wire logic write_high_byte_strobe_n, // high byte write strobe, active low
    input wire logic [`ADDR_W-1:0] addr, // low address lines a0..a3
    input wire logic byte_bus_mode, // 1: byte-wide data bus
    input wire logic [`CNT_W-1:0] wait_clock_count, // wait clocks per sequence
    input wire logic [`MODE_W-1:0] wait_mode, // 0 reg, 1 comb, 2 one-shot
    input wire logic stage_tap_en, // end on a shift-stage tap instead
    input wire logic [`TAP_W-1:0] stage_tap, // selected stage when tapping
    output logic wait_out, // wait request to the processor, high active
    output logic first_count_stage, // first counter stage set
    output logic addr_latch_open, // address latch transparent
    output logic [`CNT_W-1:0] count_value, // current wait count
    output logic [`STAGE_N-1:0] stage_view, // shift-register style stages
    output logic busy, // sequence in progress
    output logic retrigger, // burst address change seen, pulse
    output logic sequence_done, // wait sequence completed, pulse
    output logic abandoned, // strobe released before wait ended, pulse
    output logic [`CNT_W-1:0] last_seq_len // wait clocks of the last sequence
);
    wait_gen_pkg::gen_s s_q;
    wait_gen_pkg::gen_s s_d;
    wait_gen_pkg::wait_mode_e mode;
    wait_gen_pkg::count_t target;
    wait_gen_pkg::count_t tap_count;
    logic strobe_any;
    logic read_strobe;
    logic active;
    logic addr_equal;
    logic eq_gated;
    logic eq_rise;
    logic addr_changed;
    logic reached_q;
    logic reached_d;
    logic wait_comb;
    logic [`ADDR_W-1:0] latched_addr;

    assign mode = wait_gen_pkg::wait_mode_e'(wait_mode);

    assign strobe_any = ~(code_read_strobe_n & data_read_strobe_n &
        write_low_byte_strobe_n & write_high_byte_strobe_n);
    assign read_strobe = ~code_read_strobe_n | ~data_read_strobe_n;
    assign active = strobe_any & ~chip_select_n;

    // a tap on stage k ends the wait once k+1 ones are shifted in
    assign tap_count = `CNT_W'({1'b0, stage_tap} + `CNT_W'(1));
    assign target = stage_tap_en ? tap_count : wait_clock_count;

    assign addr_latch_open = (s_q.count == `COUNT_ZERO);

    addr_watch u_watch (
        .mclk(mclk),
        .rstn(rstn),
        .addr(addr),
        .byte_bus_mode(byte_bus_mode),
        .addr_latch_open(addr_latch_open),
        .latched_addr(latched_addr),
        .addr_equal(addr_equal)
    );

    assign eq_gated = active & addr_equal;
    assign eq_rise = eq_gated & ~s_q.eq_prev;
    // burst: read held low, latch closed, and a watched line moved
    assign addr_changed = active & read_strobe & ~addr_latch_open & ~addr_equal;

    assign reached_q = (s_q.count >= target);
    assign reached_d = (s_d.count >= target);

    genvar k;
    generate
        for (k = 0; k < `STAGE_N; k = k + 1) begin : g_stage
            assign stage_view[k] = (s_q.count > `CNT_W'(k));
        end
    endgenerate

    // combinational path follows the strobe at once, at the cost of glitch risk
    assign wait_comb = active & (~reached_q | addr_changed);

    always_comb begin
        s_d = s_q;
        s_d.eq_prev = eq_gated;
        s_d.strobe_prev = active;
        s_d.retrig = 1'b0;
        s_d.done_pulse = 1'b0;
        s_d.abandon = 1'b0;
        if (!active) begin
            s_d.count = `COUNT_ZERO;
            s_d.phase = wait_gen_pkg::PH_IDLE;
            if (s_q.phase == wait_gen_pkg::PH_COUNTING) begin
                s_d.abandon = 1'b1;
            end
        end else if (addr_changed) begin
            // reopen the latch at the next edge; the edge after that captures the new address
            s_d.count = `COUNT_ZERO;
            s_d.retrig = 1'b1;
            s_d.phase = wait_gen_pkg::PH_COUNTING;
        end else begin
            case (mode)
                wait_gen_pkg::WM_ONESHOT: begin
                    if (s_q.count == `COUNT_ZERO) begin
                        if (eq_rise) begin
                            s_d.count = `COUNT_ONE;
                        end
                    end else if (!reached_q) begin
                        s_d.count = `CNT_W'(s_q.count + `COUNT_ONE);
                    end
                end
                default: begin
                    if (!reached_q) begin
                        s_d.count = `CNT_W'(s_q.count + `COUNT_ONE);
                    end
                    // else hold the count so the wait stays low
                end
            endcase
            case (s_q.phase)
                wait_gen_pkg::PH_IDLE: begin
                    s_d.phase = wait_gen_pkg::PH_COUNTING;
                end
                wait_gen_pkg::PH_COUNTING: begin
                    if (reached_d) begin
                        s_d.phase = wait_gen_pkg::PH_DONE;
                        s_d.done_pulse = 1'b1;
                        s_d.seq_len = s_d.count;
                    end
                end
                wait_gen_pkg::PH_DONE: begin
                    s_d.phase = wait_gen_pkg::PH_DONE;
                end
                default: begin
                    s_d.phase = wait_gen_pkg::PH_IDLE;
                end
            endcase
        end
        // registered wait rises one edge after the strobe, so after it fell
        s_d.wait_reg = active & ~addr_changed & ~reached_d;
        if (addr_changed) begin
            s_d.wait_reg = 1'b1;
        end
        s_d.busy = active & ~reached_d;
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // registered wait lands a clock late on one-clock strobes; the
    // combinational mode meets the early deadline instead
    always_comb begin
        case (mode)
            wait_gen_pkg::WM_COMB: wait_out = wait_comb;
            default: wait_out = s_q.wait_reg & active;
        endcase
    end

    assign first_count_stage = (s_q.count != `COUNT_ZERO);
    assign count_value = s_q.count;
    assign busy = s_q.busy;
    assign retrigger = s_q.retrig;
    assign sequence_done = s_q.done_pulse;
    assign abandoned = s_q.abandon;
    assign last_seq_len = s_q.seq_len;

endmodule

// File: verilog/wait_gen_map.svh
`ifndef WAIT_GEN_MAP_SVH
`define WAIT_GEN_MAP_SVH

// widths
`define ADDR_W 4
`define CNT_W 4
`define MODE_W 2
`define STAGE_N 8
`define TAP_W 3

// watched address bits: a1..a3 always, a0 only in byte-wide bus mode
`define ADDR_LOW_BIT 0
`define ADDR_WORD_MASK 4'he
`define ADDR_BYTE_MASK 4'hf

// wait length
`define WAIT_COUNT_DEFAULT 4'h6
`define COUNT_ZERO 4'h0
`define COUNT_ONE 4'h1

// wait mode encodings on the wait_mode input
`define MODE_REG 2'h0
`define MODE_COMB 2'h1
`define MODE_ONESHOT 2'h2

// timing
`define CLK_PERIOD_NS 40
`define WAIT_SETUP_NS 34
`define STROBE_DELAY_NS 17
`define INV_CLK_MAX_MHZ 45
// least time: round up, at least one cycle
`define WAIT_SETUP_CYC \
    (((`WAIT_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
    ((`WAIT_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define STROBE_DELAY_CYC \
    (((`STROBE_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
    ((`STROBE_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))

`endif

// File: verilog/wait_gen_pkg.sv
`include "wait_gen_map.svh"

package wait_gen_pkg;

    typedef enum logic [1:0] {
        WM_REG,
        WM_COMB,
        WM_ONESHOT,
        WM_SPARE
    } wait_mode_e;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_COUNTING,
        PH_DONE
    } phase_e;

    typedef logic [`CNT_W-1:0] count_t;
    typedef logic [`ADDR_W-1:0] addr_t;

    typedef struct packed {
        addr_t held;
    } watch_s;

    typedef struct packed {
        count_t count;
        logic wait_reg;
        logic eq_prev;
        logic strobe_prev;
        logic busy;
        logic retrig;
        logic done_pulse;
        logic abandon;
        count_t seq_len;
        phase_e phase;
    } gen_s;

endpackage
